/* rtl/woc_cache_ctrl.sv */
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/100ps
module woc_cache_ctrl (
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     clk_en,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [woc_pkg::WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire woc_pkg::woc_req_t        req,
  output woc_pkg::woc_rsp_t             rsp,
  output logic                          l1_inval,
  output logic      [31:0]              l1_inval_addr,
  input  wire woc_pkg::woc_snoop_t      snoop,
  output logic                          snoop_ack,
  output woc_pkg::woc_mcmd_t            mcmd,
  input  wire logic                     mcmd_ready,
  output logic                          mem_wvalid,
  output logic      [63:0]              mem_wdata,
  input  wire logic                     mem_rvalid,
  input  wire logic [63:0]              mem_rdata,
  input  wire logic                     mem_rerr
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [woc_pkg::IDX_W-1:0] idx_of(input logic [31:0] a);
    return a[woc_pkg::IDX_LSB +: woc_pkg::IDX_W];
  endfunction : idx_of

  function automatic logic [woc_pkg::QW_W-1:0] qw_of(input logic [31:0] a);
    return a[woc_pkg::QW_LSB +: woc_pkg::QW_W];
  endfunction : qw_of

  function automatic logic [woc_pkg::TAG_W-1:0] tag_of(input logic [31:0] a);
    return a[woc_pkg::TAG_LSB +: woc_pkg::TAG_W];
  endfunction : tag_of

  function automatic logic [31:0] blk_addr(input logic [woc_pkg::TAG_W-1:0] t,
                                           input logic [woc_pkg::IDX_W-1:0] i);
    logic [31:0] a;
    a = '0;
    a[woc_pkg::TAG_LSB +: woc_pkg::TAG_W] = t;
    a[woc_pkg::IDX_LSB +: woc_pkg::IDX_W] = i;
    return a;
  endfunction : blk_addr

  function automatic woc_pkg::woc_cmd_t fill_cmd(input woc_pkg::woc_kind_t k);
    case (k)
      woc_pkg::KIND_INSTRUCTION_READ: fill_cmd = woc_pkg::CMD_INSTRUCTION_STREAM_READ;
      woc_pkg::KIND_DATA_READ:        fill_cmd = woc_pkg::CMD_DATA_STREAM_READ;
      default:                        fill_cmd = woc_pkg::CMD_OWNERSHIP_READ;
    endcase
  endfunction : fill_cmd

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  woc_pkg::woc_state_t        state_reg;
  woc_pkg::woc_blk_t          st_reg   [woc_pkg::SETS];
  logic [woc_pkg::TAG_W-1:0]  tag_reg  [woc_pkg::SETS];
  logic [63:0]                data_reg [woc_pkg::SETS*woc_pkg::QW_PER_BLK];
  woc_pkg::woc_kind_t         kind_reg;
  logic [31:0]                addr_reg;
  logic [63:0]                wdata_reg;
  logic                       l1hit_reg;
  logic                       snoop_reg;
  logic                       single_reg;
  logic                       bad_reg;
  logic [1:0]                 beat_reg;
  logic                       en_reg;
  logic                       fh_reg;
  logic                       etm_reg;
  logic                       fault_reg;
  woc_pkg::woc_rsp_t          rsp_reg;
  woc_pkg::woc_mcmd_t         mcmd_reg;
  logic                       l1_inval_reg;
  logic [31:0]                inval_addr_reg;
  logic                       snoop_ack_reg;
  logic                       mem_wvalid_reg;
  logic [63:0]                mem_wdata_reg;
  logic                       wb_ack_reg;
  logic [31:0]                wb_dat_reg;

  logic [woc_pkg::IDX_W-1:0]  idx_c;
  logic [woc_pkg::IDX_W-1:0]  r_idx;
  logic [woc_pkg::IDX_W-1:0]  s_idx;
  logic                       cached;
  logic                       r_match;
  logic                       s_match;
  logic                       is_wr;
  logic                       upper_hit;
  logic                       bad_now;
  logic                       err_evt;

  assign idx_c     = idx_of(addr_reg);
  assign r_idx     = idx_of(req.addr);
  assign s_idx     = idx_of(snoop.addr);
  assign cached    = en_reg && !etm_reg;
  assign r_match   = st_reg[r_idx] != woc_pkg::BLK_INVALID
                     && tag_reg[r_idx] == tag_of(req.addr);
  assign s_match   = st_reg[s_idx] != woc_pkg::BLK_INVALID
                     && tag_reg[s_idx] == tag_of(snoop.addr);
  assign is_wr     = req.kind == woc_pkg::KIND_WRITE;
  // Data reads ignore the instruction cache hit flag
  assign upper_hit = !is_wr && (req.l1_hit ||
                     (req.kind == woc_pkg::KIND_INSTRUCTION_READ && req.ic_hit));
  assign bad_now   = bad_reg || mem_rerr;
  assign err_evt   = state_reg == woc_pkg::S_FILL_DATA && mem_rvalid && mem_rerr;

  // ------------------------------------------------------------
  // Cache sequencer
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg      <= woc_pkg::S_IDLE;
      for (int i = 0; i < woc_pkg::SETS; i++) begin
        st_reg[i]  <= woc_pkg::BLK_INVALID;
        tag_reg[i] <= '0;
      end
      kind_reg       <= woc_pkg::KIND_DATA_READ;
      addr_reg       <= '0;
      wdata_reg      <= '0;
      l1hit_reg      <= 1'b0;
      snoop_reg      <= 1'b0;
      single_reg     <= 1'b0;
      bad_reg        <= 1'b0;
      beat_reg       <= woc_pkg::FIRST_BEAT;
      rsp_reg        <= '0;
      mcmd_reg       <= '0;
      l1_inval_reg   <= 1'b0;
      inval_addr_reg <= '0;
      snoop_ack_reg  <= 1'b0;
      mem_wvalid_reg <= 1'b0;
      mem_wdata_reg  <= '0;
    end else if (clk_en) begin
      rsp_reg.valid     <= 1'b0;
      rsp_reg.l1_fill   <= 1'b0;
      rsp_reg.ic_fill   <= 1'b0;
      rsp_reg.l1_update <= 1'b0;
      l1_inval_reg      <= 1'b0;
      snoop_ack_reg     <= 1'b0;
      mem_wvalid_reg    <= 1'b0;
      case (state_reg)
        woc_pkg::S_IDLE: begin
          if (snoop.valid && !snoop_ack_reg) begin
            addr_reg   <= snoop.addr;
            snoop_reg  <= 1'b1;
            single_reg <= 1'b0;
            if (s_match && st_reg[s_idx] == woc_pkg::BLK_OWNED) begin
              mcmd_reg  <= '{1'b1, woc_pkg::CMD_DISOWN_WRITE,
                           blk_addr(tag_reg[s_idx], s_idx)};
              state_reg <= woc_pkg::S_EVICT_CMD;
            end else begin
              if (s_match && snoop.write) begin
                st_reg[s_idx]  <= woc_pkg::BLK_INVALID;
                l1_inval_reg   <= 1'b1;
                inval_addr_reg <= blk_addr(tag_reg[s_idx], s_idx);
              end
              snoop_ack_reg <= 1'b1;
            end
          end else if (req.valid && !rsp_reg.valid) begin
            addr_reg   <= req.addr;
            kind_reg   <= req.kind;
            wdata_reg  <= req.wdata;
            l1hit_reg  <= req.l1_hit;
            snoop_reg  <= 1'b0;
            single_reg <= !cached;
            bad_reg    <= 1'b0;
            if (upper_hit) begin
              rsp_reg.valid <= 1'b1;
            end else if (!cached) begin
              mcmd_reg  <= '{1'b1, is_wr ? woc_pkg::CMD_PLAIN_WRITE : fill_cmd(req.kind),
                           req.addr};
              state_reg <= is_wr ? woc_pkg::S_EVICT_CMD : woc_pkg::S_FILL_CMD;
            end else if ((fh_reg || r_match) && !is_wr) begin
              rsp_reg.valid   <= 1'b1;
              rsp_reg.rdata   <= data_reg[{r_idx, qw_of(req.addr)}];
              rsp_reg.l1_fill <= 1'b1;
              rsp_reg.ic_fill <= req.kind == woc_pkg::KIND_INSTRUCTION_READ;
            end else if (fh_reg || (r_match && st_reg[r_idx] == woc_pkg::BLK_OWNED)) begin
              data_reg[{r_idx, qw_of(req.addr)}] <= req.wdata;
              rsp_reg.valid     <= 1'b1;
              rsp_reg.l1_update <= req.l1_hit;
            end else if (!r_match && st_reg[r_idx] == woc_pkg::BLK_OWNED) begin
              mcmd_reg  <= '{1'b1, woc_pkg::CMD_DISOWN_WRITE,
                           blk_addr(tag_reg[r_idx], r_idx)};
              state_reg <= woc_pkg::S_EVICT_CMD;
            end else begin
              if (!r_match && st_reg[r_idx] != woc_pkg::BLK_INVALID) begin
                st_reg[r_idx]  <= woc_pkg::BLK_INVALID;
                l1_inval_reg   <= 1'b1;
                inval_addr_reg <= blk_addr(tag_reg[r_idx], r_idx);
              end
              // Shared hit on write keeps its slot; the whole block is refetched with an ownership read
              mcmd_reg  <= '{1'b1, fill_cmd(req.kind),
                           blk_addr(tag_of(req.addr), r_idx)};
              state_reg <= woc_pkg::S_FILL_CMD;
            end
          end
        end
        woc_pkg::S_EVICT_CMD: begin
          beat_reg <= woc_pkg::FIRST_BEAT;
          if (mcmd_ready) begin
            mcmd_reg.valid <= 1'b0;
            state_reg      <= woc_pkg::S_EVICT_DATA;
          end
        end
        woc_pkg::S_EVICT_DATA: begin
          mem_wvalid_reg <= 1'b1;
          mem_wdata_reg  <= single_reg ? wdata_reg : data_reg[{idx_c, beat_reg}];
          beat_reg       <= beat_reg + woc_pkg::BEAT_STEP;
          if (single_reg) begin
            rsp_reg.valid <= 1'b1;
            state_reg     <= woc_pkg::S_IDLE;
          end else if (beat_reg == woc_pkg::LAST_BEAT) begin
            st_reg[idx_c]  <= woc_pkg::BLK_INVALID;
            l1_inval_reg   <= 1'b1;
            inval_addr_reg <= mcmd_reg.addr;
            if (snoop_reg) begin
              snoop_ack_reg <= 1'b1;
              state_reg     <= woc_pkg::S_IDLE;
            end else begin
              mcmd_reg  <= '{1'b1, fill_cmd(kind_reg),
                           blk_addr(tag_of(addr_reg), idx_c)};
              state_reg <= woc_pkg::S_FILL_CMD;
            end
          end
        end
        woc_pkg::S_FILL_CMD: begin
          beat_reg <= woc_pkg::FIRST_BEAT;
          if (mcmd_ready) begin
            mcmd_reg.valid <= 1'b0;
            state_reg      <= woc_pkg::S_FILL_DATA;
          end
        end
        woc_pkg::S_FILL_DATA: begin
          if (mem_rvalid) begin
            beat_reg <= beat_reg + woc_pkg::BEAT_STEP;
            bad_reg  <= bad_now;
            if (!single_reg && !mem_rerr) begin
              data_reg[{idx_c, beat_reg}] <= mem_rdata;
            end
            if (beat_reg == qw_of(addr_reg)) begin
              rsp_reg.rdata <= mem_rdata;
            end
            if (beat_reg == woc_pkg::LAST_BEAT) begin
              if (!single_reg && !bad_now) begin
                tag_reg[idx_c] <= tag_of(addr_reg);
                st_reg[idx_c]  <= kind_reg == woc_pkg::KIND_WRITE ?
                                  woc_pkg::BLK_OWNED : woc_pkg::BLK_SHARED;
              end
              if (!single_reg && !bad_now && kind_reg == woc_pkg::KIND_WRITE) begin
                state_reg <= woc_pkg::S_COMPLETE;
              end else begin
                rsp_reg.valid   <= 1'b1;
                rsp_reg.l1_fill <= !single_reg && !bad_now
                                   && kind_reg != woc_pkg::KIND_WRITE;
                rsp_reg.ic_fill <= !single_reg && !bad_now
                                   && kind_reg == woc_pkg::KIND_INSTRUCTION_READ;
                state_reg       <= woc_pkg::S_IDLE;
              end
            end
          end
        end
        woc_pkg::S_COMPLETE: begin
          data_reg[{idx_c, qw_of(addr_reg)}] <= wdata_reg;
          rsp_reg.valid     <= 1'b1;
          rsp_reg.l1_update <= l1hit_reg;
          state_reg         <= woc_pkg::S_IDLE;
        end
        default: state_reg <= woc_pkg::S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Wishbone control and status
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      en_reg     <= 1'b0;
      fh_reg     <= 1'b0;
      etm_reg    <= 1'b0;
      fault_reg  <= 1'b0;
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= '0;
    end else if (clk_en) begin
      wb_ack_reg <= 1'b0;
      if (wb_cyc_i && wb_stb_i && !wb_ack_reg) begin
        wb_ack_reg <= 1'b1;
        wb_dat_reg <= '0;
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == woc_pkg::CTRL_OFF) begin
          en_reg  <= wb_dat_i[woc_pkg::CTRL_ENABLE_BIT];
          fh_reg  <= wb_dat_i[woc_pkg::CTRL_FORCE_BIT];
          etm_reg <= wb_dat_i[woc_pkg::CTRL_ERRMODE_BIT];
        end
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == woc_pkg::STAT_OFF
            && wb_dat_i[woc_pkg::STAT_FAULT_BIT]) begin
          fault_reg <= 1'b0;
        end
        if (!wb_we_i && wb_adr_i == woc_pkg::CTRL_OFF) begin
          wb_dat_reg[woc_pkg::CTRL_ENABLE_BIT]  <= en_reg;
          wb_dat_reg[woc_pkg::CTRL_FORCE_BIT]   <= fh_reg;
          wb_dat_reg[woc_pkg::CTRL_ERRMODE_BIT] <= etm_reg;
        end
        if (!wb_we_i && wb_adr_i == woc_pkg::STAT_OFF) begin
          wb_dat_reg[woc_pkg::STAT_ERRMODE_BIT] <= etm_reg;
          wb_dat_reg[woc_pkg::STAT_FAULT_BIT]   <= fault_reg;
          wb_dat_reg[woc_pkg::STAT_BUSY_BIT]    <= state_reg != woc_pkg::S_IDLE;
        end
      end
      // Hardware error wins over a same-cycle software clear
      if (err_evt) begin
        etm_reg   <= 1'b1;
        fault_reg <= 1'b1;
      end
    end
  end

  assign wb_dat_o      = wb_dat_reg;
  assign wb_ack_o      = wb_ack_reg;
  assign rsp           = rsp_reg;
  assign l1_inval      = l1_inval_reg;
  assign l1_inval_addr = inval_addr_reg;
  assign snoop_ack     = snoop_ack_reg;
  assign mcmd          = mcmd_reg;
  assign mem_wvalid    = mem_wvalid_reg;
  assign mem_wdata     = mem_wdata_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_reset_cache_off: assert property (@(posedge core_clk)
    $fell(sys_rst) |-> !en_reg && !fh_reg)
    else $error("cache not off after reset");
  a_victim_written_first: assert property (@(posedge core_clk)
    disable iff (sys_rst || !clk_en)
    state_reg == woc_pkg::S_FILL_CMD && $past(state_reg) == woc_pkg::S_IDLE
    |-> single_reg || st_reg[idx_c] != woc_pkg::BLK_OWNED
        || tag_reg[idx_c] == tag_of(addr_reg))
    else $error("owned victim displaced without disown write");
  a_owned_write_local: assert property (@(posedge core_clk)
    disable iff (sys_rst || !clk_en)
    state_reg == woc_pkg::S_IDLE && !(snoop.valid && !snoop_ack_reg) && req.valid
    && !rsp_reg.valid && is_wr && cached && r_match
    && st_reg[r_idx] == woc_pkg::BLK_OWNED
    |=> rsp_reg.valid && !mcmd_reg.valid ##1 state_reg == woc_pkg::S_IDLE)
    else $error("owned write hit went to memory");
  a_disown_invalidates: assert property (@(posedge core_clk)
    disable iff (sys_rst || !clk_en)
    state_reg == woc_pkg::S_EVICT_DATA && !single_reg && beat_reg == woc_pkg::LAST_BEAT
    |=> l1_inval_reg && st_reg[idx_of(l1_inval_addr)] == woc_pkg::BLK_INVALID)
    else $error("write-back without invalidate");
  a_complete_owned: assert property (@(posedge core_clk)
    disable iff (sys_rst || !clk_en)
    state_reg == woc_pkg::S_COMPLETE
    |-> st_reg[idx_c] == woc_pkg::BLK_OWNED ##1 rsp_reg.valid)
    else $error("write completed without ownership");
  a_no_write_alloc: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    rsp_reg.valid && rsp_reg.l1_fill |-> kind_reg != woc_pkg::KIND_WRITE
    && !(rsp_reg.l1_update && !l1hit_reg))
    else $error("write allocated in first level");
  a_io_read_keeps: assert property (@(posedge core_clk)
    disable iff (sys_rst || !clk_en)
    state_reg == woc_pkg::S_IDLE && snoop.valid && !snoop_ack_reg && !snoop.write
    && s_match && st_reg[s_idx] == woc_pkg::BLK_SHARED
    |=> st_reg[$past(s_idx)] == woc_pkg::BLK_SHARED && !l1_inval_reg)
    else $error("I/O read invalidated a shared block");
  a_ic_fill_istream: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    rsp_reg.ic_fill |-> rsp_reg.valid && kind_reg == woc_pkg::KIND_INSTRUCTION_READ)
    else $error("instruction cache filled on data access");
  a_error_mode_entry: assert property (@(posedge core_clk)
    disable iff (sys_rst || !clk_en)
    err_evt |=> etm_reg && fault_reg)
    else $error("error did not enter error transition mode");
  a_wb_ack_pulse: assert property (@(posedge core_clk)
    disable iff (sys_rst || !clk_en)
    wb_ack_reg |=> !wb_ack_reg)
    else $error("bus ack longer than one cycle");

endmodule : woc_cache_ctrl

/* rtl/woc_pkg.sv */
package woc_pkg;
  localparam int ADDR_W     = 32;
  localparam int DATA_W     = 64;
  localparam int QW_PER_BLK = 4;
  localparam int QW_LSB     = 3;
  localparam int QW_W       = 2;
  localparam int IDX_LSB    = 5;
  localparam int IDX_W      = 4;
  localparam int SETS       = 16;
  localparam int TAG_LSB    = 9;
  localparam int TAG_W      = 20;
  localparam logic [1:0] LAST_BEAT  = 2'h3;
  localparam logic [1:0] FIRST_BEAT = 2'h0;
  localparam logic [1:0] BEAT_STEP  = 2'h1;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int WB_AW = 4;
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] STAT_OFF = 4'h4;
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_FORCE_BIT   = 1;
  localparam int CTRL_ERRMODE_BIT = 2;
  localparam int STAT_ERRMODE_BIT = 0;
  localparam int STAT_FAULT_BIT   = 1;
  localparam int STAT_BUSY_BIT    = 2;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_INSTRUCTION_READ, KIND_DATA_READ, KIND_WRITE
  } woc_kind_t;
  typedef enum logic [2:0] {
    CMD_NONE, CMD_INSTRUCTION_STREAM_READ, CMD_DATA_STREAM_READ,
    CMD_OWNERSHIP_READ, CMD_DISOWN_WRITE, CMD_PLAIN_WRITE
  } woc_cmd_t;
  typedef enum logic [1:0] {BLK_INVALID, BLK_SHARED, BLK_OWNED} woc_blk_t;
  typedef enum {
    S_IDLE, S_EVICT_CMD, S_EVICT_DATA, S_FILL_CMD, S_FILL_DATA, S_COMPLETE
  } woc_state_t;

  typedef struct packed {
    logic              valid;
    woc_kind_t         kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              l1_hit;
    logic              ic_hit;
  } woc_req_t;
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] rdata;
    logic              l1_fill;
    logic              ic_fill;
    logic              l1_update;
  } woc_rsp_t;
  typedef struct packed {
    logic              valid;
    woc_cmd_t          cmd;
    logic [ADDR_W-1:0] addr;
  } woc_mcmd_t;
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } woc_snoop_t;
endpackage : woc_pkg

/* tb/tb.sv */
`timescale 1ns/100ps
module tb;
  logic core_clk = 0;
  logic sys_rst = 1;
  logic cyc = 0;
  logic rerr = 0;
  logic we = 0;
  logic [3:0] adr = 0;
  logic [31:0] wdat = 0, q, l1_inval_addr, dat_o, a, c;
  logic rdy, rvalid, l1_inval, snoop_ack, ack, wv;
  logic [63:0] rdat, wd, wdo, lw;
  woc_pkg::woc_req_t req = '0;
  woc_pkg::woc_snoop_t snoop = '0;
  woc_pkg::woc_rsp_t rsp, r;
  woc_pkg::woc_mcmd_t mcmd;
  woc_pkg::woc_cmd_t lc, pc;
  int err_total = 0, checks_done = 0, nc = 0, nw = 0, ni = 0, n0, w0, i0;
  int seed = 32'hf99ac780;
  woc_cache_ctrl DUT (.core_clk, .sys_rst, .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .req, .rsp, .l1_inval, .l1_inval_addr, .snoop, .snoop_ack, .mcmd,
    .mcmd_ready(rdy), .mem_wvalid(wv), .mem_wdata(wdo), .mem_rvalid(rvalid),
    .mem_rdata(rdat), .mem_rerr(rerr));
  woc_mem_model mem (.core_clk, .mcmd, .mcmd_ready(rdy), .mem_rvalid(rvalid),
    .mem_rdata(rdat));
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (mcmd.valid && rdy) begin
      pc <= lc;
      lc <= mcmd.cmd;
      nc <= nc + 1;
    end
    nw <= nw + (wv === 1'b1);
    ni <= ni + (l1_inval === 1'b1);
    if (wv === 1'b1) lw <= wdo;
  end
  function automatic logic [63:0] pat(input logic [31:0] x);
    return {~{x[31:3], 3'h0}, x[31:3], 3'h0};
  endfunction : pat
  task automatic chk(input logic [127:0] s, input logic [127:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge core_clk);
    {cyc, we, adr, wdat} <= {1'b1, w, ad, d};
    do @(posedge core_clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
  endtask : wb
  task automatic cpu(input woc_pkg::woc_kind_t k, input logic [31:0] x, input logic l1, ic);
    n0 = nc;
    w0 = nw;
    i0 = ni;
    @(posedge core_clk);
    req <= '{1'b1, k, x, wd, l1, ic};
    do @(posedge core_clk); while (rsp.valid !== 1'b1);
    r = rsp;
    req.valid <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : cpu
  task automatic snp(input logic w, input logic [31:0] x);
    n0 = nc;
    w0 = nw;
    i0 = ni;
    @(posedge core_clk);
    snoop <= '{1'b1, w, x};
    do @(posedge core_clk); while (snoop_ack !== 1'b1);
    snoop.valid <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : snp
  initial begin
    #300000;
    err_total++;
    conclude;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    wb(0, woc_pkg::CTRL_OFF, 0);
    chk(q, 0);
    wb(1, woc_pkg::CTRL_OFF, 32'h1);
    wb(0, woc_pkg::CTRL_OFF, 0);
    chk(q, 1);
    a = 32'h10000040 | (32'($random(seed)) & 32'h18);
    c = a + 32'h200;
    wd = {$random(seed), $random(seed)};
    cpu(woc_pkg::KIND_DATA_READ, a, 0, 0);
    chk({lc, r.l1_fill, r.ic_fill, r.rdata}, {woc_pkg::CMD_DATA_STREAM_READ, 2'b10, pat(a)});
    cpu(woc_pkg::KIND_DATA_READ, a, 0, 0);
    chk({nc - n0, r.l1_fill, r.rdata}, {32'h0, 1'b1, pat(a)});
    cpu(woc_pkg::KIND_INSTRUCTION_READ, 32'h80, 0, 0);
    chk({lc, r.ic_fill}, {woc_pkg::CMD_INSTRUCTION_STREAM_READ, 1'b1});
    cpu(woc_pkg::KIND_INSTRUCTION_READ, 32'h80, 0, 1);
    chk({nc - n0, r.l1_fill, r.ic_fill}, 0);
    $display("test reads done");
    cpu(woc_pkg::KIND_WRITE, a, 1, 0);
    chk({lc, r.l1_update}, {woc_pkg::CMD_OWNERSHIP_READ, 1'b1});
    wd = ~wd;
    cpu(woc_pkg::KIND_WRITE, a, 0, 0);
    chk({nc - n0, r.l1_update}, {32'h0, 1'b0});
    cpu(woc_pkg::KIND_DATA_READ, a, 0, 0);
    chk(r.rdata, wd);
    cpu(woc_pkg::KIND_DATA_READ, c, 0, 0);
    chk({pc, lc, nw - w0}, {woc_pkg::CMD_DISOWN_WRITE, woc_pkg::CMD_DATA_STREAM_READ, 32'h4});
    chk(l1_inval_addr, {a[31:5], 5'h0});
    $display("test writes done");
    snp(0, c);
    chk({nc - n0, ni - i0}, 0);
    snp(1, c);
    chk({ni - i0, l1_inval_addr}, {32'h1, c[31:5], 5'h0});
    cpu(woc_pkg::KIND_WRITE, 32'h100, 0, 0);
    chk(mem.own_reg[8], 1);
    snp(0, 32'h100);
    chk({lc, nw - w0, lw}, {woc_pkg::CMD_DISOWN_WRITE, 32'h4, pat(32'h118)});
    chk(mem.own_reg[8], 0);
    $display("test snoops done");
    rerr <= 1'b1;
    cpu(woc_pkg::KIND_DATA_READ, 32'h2a0, 0, 0);
    rerr <= 1'b0;
    chk({lc, r.l1_fill, r.ic_fill}, {woc_pkg::CMD_DATA_STREAM_READ, 2'b00});
    wb(0, woc_pkg::STAT_OFF, 0);
    chk(q, 32'h3);
    wb(1, woc_pkg::STAT_OFF, 32'h2);
    wb(0, woc_pkg::STAT_OFF, 0);
    chk(q, 32'h1);
    wb(1, woc_pkg::CTRL_OFF, 32'h3);
    cpu(woc_pkg::KIND_WRITE, 32'h180, 0, 0);
    chk(nc - n0, 0);
    cpu(woc_pkg::KIND_DATA_READ, 32'h180, 0, 0);
    chk({nc - n0, r.rdata}, {32'h0, wd});
    wb(1, woc_pkg::CTRL_OFF, 32'h5);
    wb(0, woc_pkg::STAT_OFF, 0);
    chk(q[woc_pkg::STAT_ERRMODE_BIT], 1);
    cpu(woc_pkg::KIND_WRITE, 32'h1c0, 0, 0);
    chk({lc, nw - w0, lw}, {woc_pkg::CMD_PLAIN_WRITE, 32'h1, wd});
    cpu(woc_pkg::KIND_DATA_READ, 32'h1d8, 0, 0);
    chk({lc, r.l1_fill, r.rdata}, {woc_pkg::CMD_DATA_STREAM_READ, 1'b0, pat(32'h1d8)});
    wb(1, woc_pkg::CTRL_OFF, 0);
    wb(0, woc_pkg::CTRL_OFF, 0);
    chk(q, 0);
    $display("test modes done");
    conclude;
  end
endmodule : tb

/* tb/woc_mem_model.sv */
`timescale 1ns/100ps
module woc_mem_model (
  input  wire logic               core_clk,
  input  wire woc_pkg::woc_mcmd_t mcmd,
  output logic                    mcmd_ready,
  output logic                    mem_rvalid,
  output logic [63:0]             mem_rdata
);
  logic [2:0]  left_reg = 3'h0;
  logic [31:0] a_reg    = 32'h0;
  logic        own_reg [16];
  initial begin
    mcmd_ready = 1'b0;
    mem_rvalid = 1'b0;
    mem_rdata  = 64'h0;
  end
  // Ready alternates so commands meet prompt and slow acceptance
  always @(posedge core_clk) begin
    mcmd_ready <= ~mcmd_ready;
    mem_rvalid <= left_reg != 3'h0;
    mem_rdata  <= (left_reg != 3'h0) ? {~a_reg, a_reg} : ~mem_rdata;
    if (left_reg != 3'h0) begin
      left_reg   <= left_reg - 3'h1;
      a_reg[4:3] <= a_reg[4:3] + 2'h1;
    end
    if (mcmd.valid && mcmd_ready) begin
      if (mcmd.cmd != woc_pkg::CMD_DISOWN_WRITE && mcmd.cmd != woc_pkg::CMD_PLAIN_WRITE) begin
        left_reg <= 3'h4;
        // Beats always run quadword 0 to 3 of the block
        a_reg    <= {mcmd.addr[31:5], 5'h0};
      end
      // Records ownership per block index; any later command to that index other than an ownership read clears it
      own_reg[mcmd.addr[8:5]] <= mcmd.cmd == woc_pkg::CMD_OWNERSHIP_READ;
    end
  end
endmodule : woc_mem_model
